// ### verilog/fhp_ctrl.sv
// floppy head positioning control: read id, recalibrate, seek and sense.
// assumes a classic wishbone master and a drive on the pin side.
// What this block does
// - only read id, recalibrate and seek raise the completion interrupt
// - read id stores cylinder, head, sector, size of first good id field
// - no id mark by second index: code 01, missing mark set, end
// - recalibrate zeroes the drive's cylinder and watches track zero
// - while track zero input low, direction outward and keep stepping
// - track zero input high ends recalibrate with seek end set
// - still low after 79 steps: seek end and equipment check set
// - busy only in command phase, drives may step in parallel
// - seek with present below new steps inward, direction 1
// - seek with present above new steps outward; equal gives no step
// - steps are spaced by the programmed step interval code
// - after each seek step compare; on equality set seek end, end
// - head bit in status zero reads 0 after a seek
// - leaving power down clears all cylinders and stored status
// - sense interrupt clears one pending end, reports its code and seek end
// - normal end: seek end 1 code 00; abnormal: seek end 1 code 01
// - equipment check sits at bit 4 of status zero
`default_nettype none
module fhp_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // drive side
  input  wire logic        track_zero_n_i,
  input  wire logic        index_pulse_n_i,
  input  wire logic        id_valid_i,
  input  wire logic [31:0] id_field_i,
  input  wire logic        power_down_exit_i,
  output logic [1:0]       drive_sel_o,
  output logic             step_o,
  output logic             step_direction_o,
  output logic             busy_o,
  output logic             controller_irq_o
);
  typedef enum logic [1:0] {
    FHP_IDLE = 2'b00,
    FHP_CMD  = 2'b01,
    FHP_RDID = 2'b10
  } fhp_state_e;

  fhp_state_e  state_q;
  logic [7:0]  pcyl_q  [4]; // one per drive
  logic [7:0]  ncyl_q  [4];
  logic [3:0]  active_q;    // drive is stepping
  logic [3:0]  recal_q;     // stepping is a recalibrate
  logic [6:0]  nsteps_q [4];
  logic [3:0]  done_q;      // drive finished, waiting for sense
  logic [7:0]  st0_q   [4];
  logic [7:0]  stat0_q;     // status last reported by sense or read id
  logic [7:0]  st1_q;
  logic [31:0] id_q;
  logic [3:0]  timing_q;
  logic [7:0]  newcyl_q;
  logic [1:0]  cmd_drv_q;
  logic [3:0]  cmd_code_q;
  logic        rdid_irq_q;
  logic [1:0]  idx_seen_q;
  logic        idx_prev_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [3:0]  st_pulse;
  logic [3:0]  st_done;
  logic [3:0]  st_busy;
  logic [3:0]  st_start;
  logic        wr_cmd;
  logic [1:0]  wr_drv;
  logic        sense_go;
  logic        idx_fall;
  logic [1:0]  sense_drv;
  logic        sense_hit;

  // the lowest-numbered drive with a pending end is reported by the next sense
  always_comb begin
    sense_drv = 2'd0;
    sense_hit = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (done_q[i]) begin
        sense_drv = 2'(i);
        sense_hit = 1'b1;
      end
    end
  end

  // command write: a single-cycle ack, so each access takes effect once
  assign wr_cmd = cyc_i && stb_i && we_i && !ack_q && sel_i[0]
                  && adr_i == fhp_pkg::ADDR_CMD && state_q == FHP_IDLE;
  assign wr_drv = dat_i[fhp_pkg::CMD_DRV_LSB +: 2];
  assign idx_fall = idx_prev_q && !index_pulse_n_i;

  // wishbone ack and read mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else if (ce_i) begin
      ack_q <= cyc_i && stb_i && !ack_q;
      unique case (adr_i)
        fhp_pkg::ADDR_CMD:    dat_q <= {28'h000_0000, cmd_code_q};
        fhp_pkg::ADDR_NEWCYL: dat_q <= {24'h00_0000, newcyl_q};
        fhp_pkg::ADDR_TIMING: dat_q <= {28'h000_0000, timing_q};
        fhp_pkg::ADDR_STAT0:  dat_q <= {16'h0000, st1_q, stat0_q};
        fhp_pkg::ADDR_PCYL:   dat_q <= {pcyl_q[3], pcyl_q[2],
                                        pcyl_q[1], pcyl_q[0]};
        fhp_pkg::ADDR_IDREG:  dat_q <= id_q;
        fhp_pkg::ADDR_CTRL:   dat_q <= {26'h000_0000, done_q,
                                        busy_o, controller_irq_o};
        default:              dat_q <= '0;
      endcase
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // plain setting registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timing_q <= fhp_pkg::TIMING_RESET;
      newcyl_q <= 8'h00;
    end else if (ce_i && cyc_i && stb_i && we_i && !ack_q && sel_i[0]) begin
      if (adr_i == fhp_pkg::ADDR_TIMING) timing_q <= dat_i[3:0];
      if (adr_i == fhp_pkg::ADDR_NEWCYL) newcyl_q <= dat_i[7:0];
    end
  end

  // command phase: one cycle busy for seek and recalibrate, read id holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= FHP_IDLE;
      cmd_code_q <= 4'h0;
      cmd_drv_q  <= 2'd0;
      idx_seen_q <= 2'd0;
      idx_prev_q <= 1'b1;
    end else if (ce_i) begin
      idx_prev_q <= index_pulse_n_i;
      unique case (state_q)
        FHP_IDLE: begin
          if (wr_cmd) begin
            cmd_code_q <= dat_i[3:0];
            cmd_drv_q  <= wr_drv;
            idx_seen_q <= 2'd0;
            state_q    <= (dat_i[3:0] == fhp_pkg::CMD_READ_ID)
                          ? FHP_RDID : FHP_CMD;
          end
        end
        FHP_CMD: state_q <= FHP_IDLE;
        FHP_RDID: begin
          if (id_valid_i || idx_seen_q == 2'd2) state_q <= FHP_IDLE;
          else if (idx_fall) idx_seen_q <= idx_seen_q + 2'd1;
        end
        default: state_q <= FHP_IDLE; // unused code falls back to idle
      endcase
    end
  end
  assign busy_o = state_q != FHP_IDLE;
  assign drive_sel_o = cmd_drv_q;

  // read id result and its interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      id_q       <= '0;
      st1_q      <= 8'h00;
      rdid_irq_q <= 1'b0;
    end else if (ce_i) begin
      if (power_down_exit_i) begin
        st1_q      <= 8'h00;
        rdid_irq_q <= 1'b0;
      end else if (state_q == FHP_RDID && id_valid_i) begin
        id_q       <= id_field_i;
        st1_q      <= 8'h00;
        rdid_irq_q <= 1'b1;
      end else if (state_q == FHP_RDID && idx_seen_q == 2'd2) begin
        st1_q      <= 8'h01;
        rdid_irq_q <= 1'b1;
      end else if (sense_go && !sense_hit) begin
        rdid_irq_q <= 1'b0;
      end
    end
  end

  assign sense_go = state_q == FHP_CMD && cmd_code_q == fhp_pkg::CMD_SENSE_INT;

  // reported status zero: sense loads one drive's end status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat0_q <= 8'h00;
    end else if (ce_i) begin
      if (power_down_exit_i) begin
        stat0_q <= 8'h00;
      end else if (state_q == FHP_RDID && idx_seen_q == 2'd2
                   && !id_valid_i) begin
        stat0_q <= {fhp_pkg::IC_ABNORMAL, 4'h0, cmd_drv_q};
      end else if (state_q == FHP_RDID && id_valid_i) begin
        stat0_q <= {fhp_pkg::IC_NORMAL, 4'h0, cmd_drv_q};
      end else if (sense_go && sense_hit) begin
        stat0_q <= st0_q[sense_drv];
      end
    end
  end

  // one stepper per drive so seeks overlap
  for (genvar g = 0; g < 4; g++) begin : g_drv
    assign st_start[g] = active_q[g] && !st_busy[g] && !st_done[g]
                         && (recal_q[g] ? !track_zero_n_i == 1'b0
                             ? 1'b0 : nsteps_q[g] < fhp_pkg::RECAL_MAX_STEPS
                             : pcyl_q[g] != ncyl_q[g]);
    fhp_stepper u_step (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .ce_i            (ce_i),
      .start_i         (st_start[g]),
      .abort_i         (power_down_exit_i),
      .interval_code_i (timing_q),
      .pulse_o         (st_pulse[g]),
      .step_done_o     (st_done[g]),
      .busy_o          (st_busy[g])
    );
  end

  // per-drive position, stepping and end status
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && power_down_exit_i)) begin
      for (int i = 0; i < 4; i++) begin
        pcyl_q[i]   <= 8'h00;
        ncyl_q[i]   <= 8'h00;
        nsteps_q[i] <= 7'd0;
        st0_q[i]    <= 8'h00;
      end
      active_q <= 4'h0;
      recal_q  <= 4'h0;
      done_q   <= 4'h0;
    end else if (ce_i) begin
      for (int i = 0; i < 4; i++) begin
        if (state_q == FHP_CMD && cmd_drv_q == 2'(i)
            && (cmd_code_q == fhp_pkg::CMD_RECAL
                || cmd_code_q == fhp_pkg::CMD_SEEK)) begin
          active_q[i] <= 1'b1;
          done_q[i]   <= 1'b0;
          nsteps_q[i] <= 7'd0;
          recal_q[i]  <= cmd_code_q == fhp_pkg::CMD_RECAL;
          ncyl_q[i]   <= newcyl_q;
          if (cmd_code_q == fhp_pkg::CMD_RECAL) begin
            pcyl_q[i] <= 8'h00;
            ncyl_q[i] <= 8'h00;
          end
        end else if (active_q[i] && !st_busy[i]) begin
          if (recal_q[i] && track_zero_n_i) begin
            active_q[i] <= 1'b0;
            done_q[i]   <= 1'b1;
            st0_q[i]    <= {fhp_pkg::IC_NORMAL, 6'b10_0000} | 8'(i);
          end else if (recal_q[i]
                       && nsteps_q[i] == fhp_pkg::RECAL_MAX_STEPS) begin
            active_q[i] <= 1'b0;
            done_q[i]   <= 1'b1;
            st0_q[i]    <= {fhp_pkg::IC_ABNORMAL, 6'b11_0000} | 8'(i);
          end else if (!recal_q[i] && pcyl_q[i] == ncyl_q[i]) begin
            active_q[i] <= 1'b0;
            done_q[i]   <= 1'b1;
            // head bit stays zero
            st0_q[i]    <= {fhp_pkg::IC_NORMAL, 6'b10_0000} | 8'(i);
          end
        end
        if (st_done[i]) begin
          nsteps_q[i] <= nsteps_q[i] + 7'd1;
          if (!recal_q[i]) begin
            pcyl_q[i] <= (pcyl_q[i] < ncyl_q[i]) ? pcyl_q[i] + 8'd1
                                                 : pcyl_q[i] - 8'd1;
          end
        end
        if (sense_go && sense_hit && sense_drv == 2'(i)) begin
          done_q[i] <= 1'b0;
        end
      end
    end
  end

  // pins: direction follows the commanded drive's relation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_direction_o <= 1'b0;
    end else if (ce_i && active_q[cmd_drv_q]) begin
      if (recal_q[cmd_drv_q]) begin
        step_direction_o <= 1'b0;
      end else begin
        step_direction_o <= pcyl_q[cmd_drv_q] < ncyl_q[cmd_drv_q];
      end
    end
  end
  assign step_o = |st_pulse;
  assign controller_irq_o = |done_q || rdid_irq_q;
endmodule : fhp_ctrl
`default_nettype wire

// ### verilog/fhp_pkg.sv
// package for the floppy head positioning block: register map, fields,
// command codes and timing constants.
// assumes a 10 MHz clock and a classic wishbone register bus.
`default_nettype none
package fhp_pkg;
  // register byte addresses
  localparam logic [4:0] ADDR_CMD    = 5'h00;
  localparam logic [4:0] ADDR_NEWCYL = 5'h04;
  localparam logic [4:0] ADDR_TIMING = 5'h08;
  localparam logic [4:0] ADDR_STAT0  = 5'h0C;
  localparam logic [4:0] ADDR_PCYL   = 5'h10;
  localparam logic [4:0] ADDR_IDREG  = 5'h14;
  localparam logic [4:0] ADDR_CTRL   = 5'h18;
  // command codes written to the command register, bits 3:0
  localparam logic [3:0] CMD_READ_ID   = 4'h1;
  localparam logic [3:0] CMD_RECAL     = 4'h2;
  localparam logic [3:0] CMD_SEEK      = 4'h3;
  localparam logic [3:0] CMD_SENSE_INT = 4'h4;
  localparam logic [3:0] CMD_OTHER     = 4'h5;
  // command register: drive select field position
  localparam int CMD_DRV_LSB = 4;
  // status_zero field positions
  localparam int ST0_SE_BIT  = 5;
  localparam int ST0_EC_BIT  = 4;
  localparam int ST0_HD_BIT  = 2;
  localparam int ST0_IC_LSB  = 6;
  // completion codes
  localparam logic [1:0] IC_NORMAL   = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  // recalibrate gives up after this many pulses
  localparam logic [6:0] RECAL_MAX_STEPS = 7'd79;
  // step pulse high time, in microseconds and cycles
  localparam int CLK_HZ         = 10_000_000;
  localparam int STEP_PULSE_US  = 4;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_US * CLK_HZ + 999_999)
                                  / 1_000_000;
  // base step interval 0.5 ms; code c gives (16 - c) * base
  localparam int STEP_BASE_US   = 500;
  localparam int STEP_BASE_CYC  = STEP_BASE_US * (CLK_HZ / 1_000_000);
  // reset values
  localparam logic [3:0] TIMING_RESET = 4'h8;
endpackage : fhp_pkg
`default_nettype wire

// ### verilog/fhp_stepper.sv
// one stepper channel: issues one step pulse per request, then waits out the interval.
// assumes start only while idle.
`default_nettype none
module fhp_stepper (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [3:0] interval_code_i,
  output logic            pulse_o,
  output logic            step_done_o,
  output logic            busy_o
);
  localparam int CW = 17;
  logic [CW-1:0] cnt_q;
  logic          busy_q;
  logic          pulse_q;

  // interval grows as the code falls, matching the usual step table
  function automatic logic [CW-1:0] interval_cycles(input logic [3:0] c);
    interval_cycles = CW'((5'd16 - {1'b0, c}) * fhp_pkg::STEP_BASE_CYC);
  endfunction : interval_cycles

  // pulse is high for a short time, then the rest of the interval idles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= '0;
      busy_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else if (ce_i) begin
      if (abort_i) begin
        busy_q  <= 1'b0;
        pulse_q <= 1'b0;
      end else if (start_i && !busy_q) begin
        busy_q  <= 1'b1;
        pulse_q <= 1'b1;
        // one short: the restart cycle completes the interval
        cnt_q   <= interval_cycles(interval_code_i) - CW'(1);
      end else if (busy_q) begin
        if (cnt_q == CW'(1)) begin
          busy_q <= 1'b0;
        end
        cnt_q <= cnt_q - CW'(1);
        if (cnt_q == interval_cycles(interval_code_i)
                     - CW'(fhp_pkg::STEP_PULSE_CYC)) begin
          pulse_q <= 1'b0;
        end
      end
    end
  end

  assign pulse_o     = pulse_q;
  assign busy_o      = busy_q;
  assign step_done_o = busy_q && cnt_q == CW'(1) && ce_i;
endmodule : fhp_stepper
`default_nettype wire

// ### sim/fhp_ctrl_assertions.sv
// checker for fhp_ctrl: bus handshake, stepping and interrupt relations.
// assumes ce_i low only while the bus is idle and no step runs, and at
// most one pending end at a time.
`default_nettype none
module fhp_ctrl_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        power_down_exit_i,
  input wire logic        step_o,
  input wire logic        step_direction_o,
  input wire logic        busy_o,
  input wire logic        controller_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic cmdw;
  // request taken, and a command write landing at its ack edge
  assign take = cyc_i && stb_i && !ack_o && ce_i;
  assign cmdw = ack_o && we_i && sel_i[0] && adr_i == fhp_pkg::ADDR_CMD;
  property p_ack; take |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_unmapped;
    take && !we_i && adr_i == 5'h1C |=> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_sense;
    cmdw && dat_i[3:0] == fhp_pkg::CMD_SENSE_INT |-> ##[1:2] !controller_irq_o;
  endproperty
  a_sense: assert property (p_sense) else $error("irq kept");
  property p_other;
    cmdw && dat_i[3:0] == fhp_pkg::CMD_OTHER && !controller_irq_o
      |=> !controller_irq_o [*8];
  endproperty
  a_other: assert property (p_other) else $error("irq raised");
  // the command phase is short: stepping must not hold busy
  property p_busy;
    cmdw && dat_i[3:0] == fhp_pkg::CMD_SEEK |-> ##[0:2] !busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy held");
  property p_pulse; $rose(step_o) |=> step_o [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("short step");
  property p_dir; step_o && $past(step_o) |-> $stable(step_direction_o);
  endproperty
  a_dir: assert property (p_dir) else $error("dir moved");
  property p_pwr;
    power_down_exit_i && ce_i |-> ##[1:2] !controller_irq_o && !step_o;
  endproperty
  a_pwr: assert property (p_pwr) else $error("pd exit");
  c_irq: cover property ($rose(controller_irq_o));
  c_step: cover property ($rose(step_o));
  c_busy: cover property ($rose(busy_o));
endmodule : fhp_ctrl_assertions
`default_nettype wire

// ### sim/fhp_drive_model.sv
// drive model: head position, track-zero sensor, free running index.
// assumes step pulses of several clocks and a level direction input.
`default_nettype none
module fhp_drive_model #(
  parameter int START_CYL = 2,
  parameter int IDX_PER   = 3000
) (
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  output logic      track_zero_n_o,
  output logic      index_pulse_n_o,
  output var int    cyl_o,
  output var int    steps_o,
  output logic      last_dir_o,
  output var int    gap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic step_q;
  int   idx_cnt;
  int   clk_cnt;
  int   last_cnt;
  initial begin
    clk_cnt = 0;
    last_cnt = 0;
    gap_o = 0;
    step_q = 1'b0;
    idx_cnt = 0;
    cyl_o = START_CYL;
    steps_o = 0;
    last_dir_o = 1'b0;
    index_pulse_n_o = 1'b1;
  end
  // head moves on the rising step edge; the stop holds it at zero
  always @(posedge clk_i) begin
    step_q <= step_i;
    clk_cnt <= clk_cnt + 1;
    // clocks between the last two rising step edges
    if (step_i && !step_q) begin
      gap_o <= clk_cnt - last_cnt;
      last_cnt <= clk_cnt;
      steps_o <= steps_o + 1;
      last_dir_o <= dir_i;
      if (dir_i) cyl_o <= cyl_o + 1;
      else if (cyl_o > 0) cyl_o <= cyl_o - 1;
    end
  end
  // sensor reads high at the outermost track
  assign track_zero_n_o = (cyl_o == 0);
  // one low clock per revolution, shortened to keep runs brief
  always @(posedge clk_i) begin
    idx_cnt <= (idx_cnt == IDX_PER - 1) ? 0 : idx_cnt + 1;
    index_pulse_n_o <= (idx_cnt != IDX_PER - 1);
  end
endmodule : fhp_drive_model
`default_nettype wire

// ### sim/fhp_ctrl_tb.sv
// top bench for fhp_ctrl: wishbone tasks, drive model, id inputs.
// assumes step code F so one step interval is 5000 clocks.
`default_nettype none
module fhp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        tz_n;
  logic        idx_n;
  logic        idv = 1'b0;
  logic [31:0] idf = 32'h0000_0000;
  logic        pde = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  sel = 4'hF;
  logic [1:0]  dsel;
  int          gap;
  logic        step;
  logic        dir;
  logic        busy;
  logic        irq;
  logic        ldir;
  int          cyl;
  int          steps;
  int          s0;
  logic [31:0] q;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #50 clk = ~clk;
  fhp_ctrl dut_u (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .track_zero_n_i(tz_n),
    .index_pulse_n_i(idx_n), .id_valid_i(idv), .id_field_i(idf),
    .power_down_exit_i(pde), .drive_sel_o(dsel), .step_o(step),
    .step_direction_o(dir), .busy_o(busy), .controller_irq_o(irq));
  fhp_drive_model drv_u (.clk_i(clk), .step_i(step), .dir_i(dir),
    .track_zero_n_o(tz_n), .index_pulse_n_o(idx_n), .cyl_o(cyl),
    .steps_o(steps), .last_dir_o(ldir), .gap_o(gap));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // one classic cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic cmd(input logic [3:0] c);
    wb(1'b1, fhp_pkg::ADDR_CMD, {28'h0, c});
  endtask : cmd
  task automatic wirq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("irq", {31'h0, irq}, 32'h1);
  endtask : wirq
  // sense clears the end and leaves status zero in q
  task automatic sense();
    cmd(fhp_pkg::CMD_SENSE_INT);
    chk("irq clr", {31'h0, irq}, 32'h0);
    wb(1'b0, fhp_pkg::ADDR_STAT0, 32'h0);
  endtask : sense
  task automatic t_regs();
    wb(1'b0, fhp_pkg::ADDR_TIMING, 32'h0);
    chk("timing", q[3:0], fhp_pkg::TIMING_RESET);
    wb(1'b0, 5'h1C, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, fhp_pkg::ADDR_TIMING, 32'h0000_000F);
    wb(1'b0, fhp_pkg::ADDR_TIMING, 32'h0);
    chk("timing", q[3:0], 4'hF);
    // a write without lane 0 must be dropped
    sel <= 4'hE;
    wb(1'b1, fhp_pkg::ADDR_TIMING, 32'h0000_0003);
    sel <= 4'hF;
    wb(1'b0, fhp_pkg::ADDR_TIMING, 32'h0);
    chk("timing lane0", q[3:0], 4'hF);
  endtask : t_regs
  task automatic t_recal();
    cmd(fhp_pkg::CMD_RECAL);
    wirq(20000);
    chk("cyl", cyl, 0);
    chk("steps", steps, 2);
    chk("dir", {31'h0, ldir}, 32'h0);
    sense();
    chk("st0", q[7:0], 8'h20);
    wb(1'b0, fhp_pkg::ADDR_PCYL, 32'h0);
    chk("pcyl", q[7:0], 8'h00);
  endtask : t_recal
  task automatic t_seek(input logic [7:0] c, input logic d, input int n);
    s0 = steps;
    wb(1'b1, fhp_pkg::ADDR_NEWCYL, {24'h0, c});
    cmd(fhp_pkg::CMD_SEEK);
    chk("busy", {31'h0, busy}, 32'h0);
    chk("drv", {30'h0, dsel}, 32'h0);
    wirq(20000);
    chk("cyl", cyl, c);
    // code F is one base interval between step edges
    if (n > 1) chk("gap", gap, fhp_pkg::STEP_BASE_CYC);
    chk("steps", steps - s0, n);
    chk("dir", {31'h0, ldir}, {31'h0, d});
    sense();
    chk("st0", q[7:0], 8'h20);
    wb(1'b0, fhp_pkg::ADDR_PCYL, 32'h0);
    chk("pcyl", q[7:0], c);
    chk("pcyl others", q[31:8], 32'h0);
  endtask : t_seek
  task automatic t_readid();
    cmd(fhp_pkg::CMD_READ_ID);
    repeat (5) @(posedge clk);
    idv <= 1'b1;
    idf <= 32'h0312_0502; // size code 2
    @(posedge clk);
    idv <= 1'b0;
    wirq(100);
    wb(1'b0, fhp_pkg::ADDR_IDREG, 32'h0);
    chk("id", q, 32'h0312_0502);
    sense();
    cmd(fhp_pkg::CMD_READ_ID);
    wirq(8000);
    wb(1'b0, fhp_pkg::ADDR_STAT0, 32'h0);
    chk("ic", q[7:6], fhp_pkg::IC_ABNORMAL);
    chk("mark", q[8], 1'b1);
    sense();
    cmd(fhp_pkg::CMD_OTHER);
    repeat (20) @(posedge clk);
    chk("no irq", {31'h0, irq}, 32'h0);
  endtask : t_readid
  // an end left pending when power-down is left must vanish
  task automatic t_pwr();
    wb(1'b1, fhp_pkg::ADDR_NEWCYL, 32'h0000_0002);
    cmd(fhp_pkg::CMD_SEEK);
    wirq(8000);
    // with the clock enable low the exit pulse must be ignored
    ce <= 1'b0;
    pde <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    pde <= 1'b0;
    @(posedge clk);
    chk("frozen irq", {31'h0, irq}, 32'h1);
    pde <= 1'b1;
    @(posedge clk);
    pde <= 1'b0;
    @(posedge clk);
    chk("pd irq", {31'h0, irq}, 32'h0);
    wb(1'b0, fhp_pkg::ADDR_PCYL, 32'h0);
    chk("pcyl", q, 32'h0);
    wb(1'b0, fhp_pkg::ADDR_STAT0, 32'h0);
    chk("st0", q[7:0], 8'h00);
  endtask : t_pwr
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_recal();
    t_seek(8'd3, 1'b1, 3);
    t_seek(8'd1, 1'b0, 2);
    t_seek(8'd1, 1'b0, 0);
    t_readid();
    t_pwr();
    close_out();
  end
  // the whole run needs about half of this span
  initial begin
    #10_000_000;
    error_cnt++;
    close_out();
  end
endmodule : fhp_ctrl_tb
bind fhp_ctrl fhp_ctrl_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .power_down_exit_i(power_down_exit_i), .step_o(step_o),
  .step_direction_o(step_direction_o), .busy_o(busy_o),
  .controller_irq_o(controller_irq_o));
`default_nettype wire
